// file: common/fsps_pkg.sv
// Constants and types for the flash suspend/lock/status-pin host controller
//
// Overview of operation
// - Host holds write-protect steady while suspended
// - Set protection: setup write, then confirm write
// - Host checks lock-bit set/clear fail, clears status on error
// - Aborted clear leaves bits unknown; host repeats
// - Pin configuration: command then code, reset high
package fsps_pkg;
  localparam int T_CLK_NS = 20;
  localparam int T_STROBE_NS = 70;
  localparam int STROBE_CYC = (T_STROBE_NS + T_CLK_NS - 1) / T_CLK_NS;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_ARRAY = 8'h10;

  localparam int CTRL_WP_BIT = 8;
  localparam int CTRL_RP_BIT = 9;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_PULSE_BIT = 4;
  localparam logic WP_RST = 1'h0;
  localparam logic RP_RST = 1'h0;

  localparam int SB_READY = 7;
  localparam int SB_SUSP = 2;
  localparam logic [7:0] FAIL_MASK = 8'h3A;

  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_LOCKSET = 8'h60;
  localparam logic [7:0] CMD_SETCONF = 8'h01;
  localparam logic [7:0] CMD_STSCFG = 8'hB8;
  localparam logic [7:0] CMD_RDSTAT = 8'h70;
  localparam logic [7:0] CMD_CLRSTAT = 8'h50;
  localparam logic [7:0] CMD_RDARRAY = 8'hFF;

  localparam logic [1:0] STS_LEVEL = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE, OP_SUSPEND, OP_RESUME, OP_SETLOCK, OP_CLRLOCK, OP_STSCFG, OP_RDSTAT, OP_RDARRAY
  } fsps_op_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_CMD1 = 3'h1, S_CMD2 = 3'h3, S_POLL = 3'h2, S_CLRS = 3'h6, S_RDA = 3'h5
  } fsps_state_e;
endpackage

// file: design/fsps_bus_cycle.sv
// One flash bus cycle: chip select, write or output strobe, hold
`timescale 1ns/100ps
module fsps_bus_cycle import fsps_pkg::*; #(
  parameter int AW = 21
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_rd,
  input wire logic [AW-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_dq,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic [AW-1:0] o_addr,
  output logic [15:0] o_dq,
  output logic o_dq_oe_n,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n
);
  logic [1:0] ph_r;
  logic [7:0] cnt_r;
  logic rd_r;

  // Address and data settle one cycle before the strobe and stay one after
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ph_r <= 2'h0;
      cnt_r <= 8'h0;
      rd_r <= 1'h0;
      o_done <= 1'h0;
      o_rdata <= '0;
      o_addr <= '0;
      o_dq <= '0;
      o_dq_oe_n <= 1'h1;
      o_ce_n <= 1'h1;
      o_we_n <= 1'h1;
      o_oe_n <= 1'h1;
    end else begin
      o_done <= 1'h0;
      case (ph_r)
        2'h0: if (i_go) begin
          ph_r <= 2'h1;
          rd_r <= i_rd;
          o_addr <= i_addr;
          o_dq <= i_wdata;
          o_dq_oe_n <= i_rd;
          o_ce_n <= 1'h0;
        end
        2'h1: begin
          ph_r <= 2'h2;
          cnt_r <= 8'(STROBE_CYC - 1);
          o_we_n <= rd_r;
          o_oe_n <= !rd_r;
        end
        2'h2: if (cnt_r == 8'h0) begin
          ph_r <= 2'h3;
          o_we_n <= 1'h1;
          o_oe_n <= 1'h1;
          if (rd_r) o_rdata <= i_dq;
        end else begin
          cnt_r <= cnt_r - 8'h1;
        end
        default: begin
          ph_r <= 2'h0;
          o_ce_n <= 1'h1;
          o_dq_oe_n <= 1'h1;
          o_done <= 1'h1;
        end
      endcase
    end
  end
endmodule

// file: design/fsps_host.sv
// Flash command host: AXI4-Lite registers, command sequencer, status pin
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module fsps_host import fsps_pkg::*; #(
  parameter int AW = 21
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [AW-1:0] O_FL_ADDR,
  output logic [15:0] O_FL_DQ,
  output logic O_FL_DQ_OE_N,
  input wire logic [15:0] I_FL_DQ,
  output logic O_FL_CE_N,
  output logic O_FL_WE_N,
  output logic O_FL_OE_N,
  output logic O_FL_WP_N,
  output logic O_FL_RP_N,
  input wire logic I_FL_STS
);
  fsps_state_e st_r, st_nxt;
  fsps_op_e op_r, op_nxt, req_op;
  logic [7:0] awaddr_r, stat_r;
  logic [31:0] wdata_r, rd_mux;
  logic [3:0] wstrb_r;
  logic [AW-1:0] addr_r;
  logic [15:0] data_r, array_r, wd_r, eng_rdata;
  logic [1:0] mode_r;
  logic susp_r, refused_r, unknown_r, pulse_r, sts_r, go_r, rd_r, eng_done;

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) m[8*i +: 8] = n[8*i +: 8];
    end
    return m;
  endfunction

  function automatic logic [15:0] cmd_word(fsps_state_e s, fsps_op_e o, logic [7:0] code);
    logic [7:0] b;
    b = CMD_RDARRAY;
    case (s)
      S_CMD1: case (o)
        OP_SUSPEND: b = CMD_SUSPEND;
        OP_RESUME: b = CMD_CONFIRM;
        OP_SETLOCK, OP_CLRLOCK: b = CMD_LOCKSET;
        OP_STSCFG: b = CMD_STSCFG;
        OP_RDSTAT: b = CMD_RDSTAT;
        default: b = CMD_RDARRAY;
      endcase
      S_CMD2: b = (o == OP_SETLOCK) ? CMD_SETCONF : (o == OP_CLRLOCK) ? CMD_CONFIRM : code;
      S_CLRS: b = CMD_CLRSTAT;
      default: b = CMD_RDARRAY;
    endcase
    return {8'h00, b};
  endfunction

  // Write channel decode; address and data may arrive in either order
  wire wr_fire = !O_AWREADY && !O_WREADY && !O_BVALID;
  wire wr_ctrl = wr_fire && awaddr_r == REG_CTRL;
  wire wr_stat = wr_fire && awaddr_r == REG_STAT;
  wire wr_ok = awaddr_r inside {REG_CTRL, REG_ADDR, REG_DATA, REG_STAT};
  wire rd_ok = I_ARADDR inside {REG_CTRL, REG_ADDR, REG_DATA, REG_STAT, REG_ARRAY};
  assign req_op = fsps_op_e'(wdata_r[2:0]);
  wire rp_new = wdata_r[CTRL_RP_BIT];
  // Dropping reset/power-down cancels any sequence in flight
  wire abort = wr_ctrl && !rp_new;
  wire op_legal = susp_r ? (req_op inside {OP_RESUME, OP_RDSTAT, OP_RDARRAY})
                         : (req_op != OP_RESUME);
  wire can_go = st_r == S_IDLE && O_FL_CE_N && O_FL_RP_N;
  wire sw_start = wr_ctrl && req_op != OP_NONE && rp_new && can_go && op_legal;
  wire refuse = wr_ctrl && req_op != OP_NONE && !sw_start;
  wire auto_go = unknown_r && can_go && !wr_ctrl;
  wire start = sw_start || auto_go;
  wire two_wr = op_r inside {OP_SETLOCK, OP_CLRLOCK, OP_STSCFG};
  wire lock_op = op_r inside {OP_SETLOCK, OP_CLRLOCK};
  wire ready = eng_rdata[SB_READY];
  wire fail = lock_op && |(eng_rdata[7:0] & FAIL_MASK);
  wire poll_end = st_r == S_POLL && eng_done && (ready || op_r == OP_RDSTAT);
  wire cfg_end = st_r == S_CMD2 && eng_done && op_r == OP_STSCFG;
  wire pulse_evt = mode_r != STS_LEVEL && !sts_r && I_FL_STS;
  wire go_nxt = st_nxt != S_IDLE && (st_nxt != st_r || eng_done);
  assign op_nxt = start ? (auto_go ? OP_CLRLOCK : req_op) : op_r;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (start) st_nxt = S_CMD1;
      S_CMD1: if (eng_done) st_nxt = two_wr ? S_CMD2 : (op_r == OP_RDARRAY) ? S_RDA : S_POLL;
      S_CMD2: if (eng_done) st_nxt = (op_r == OP_STSCFG) ? S_IDLE : S_POLL;
      S_POLL: if (poll_end) st_nxt = (fail && ready) ? S_CLRS : S_IDLE;
      S_CLRS, S_RDA: if (eng_done) st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
    if (abort) st_nxt = S_IDLE;
  end

  wire [31:0] ctrl_word = {22'h0, O_FL_RP_N, O_FL_WP_N, 5'h0, op_r};
  wire [31:0] stat_word = {14'h0, mode_r, stat_r, 2'h0, sts_r, pulse_r, unknown_r,
                           refused_r, susp_r, st_r != S_IDLE};
  assign rd_mux = (I_ARADDR == REG_CTRL) ? ctrl_word :
                  (I_ARADDR == REG_ADDR) ? 32'(addr_r) :
                  (I_ARADDR == REG_DATA) ? {16'h0, data_r} :
                  (I_ARADDR == REG_STAT) ? stat_word :
                  (I_ARADDR == REG_ARRAY) ? {16'h0, array_r} : 32'h0;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_AWREADY <= 1'h1;
      O_WREADY <= 1'h1;
      O_BVALID <= 1'h0;
      O_BRESP <= RESP_OKAY;
      awaddr_r <= 8'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        awaddr_r <= I_AWADDR;
        O_AWREADY <= 1'h0;
      end
      if (I_WVALID && O_WREADY) begin
        wdata_r <= I_WDATA;
        wstrb_r <= I_WSTRB;
        O_WREADY <= 1'h0;
      end
      if (wr_fire) begin
        O_BVALID <= 1'h1;
        O_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'h0;
        O_AWREADY <= 1'h1;
        O_WREADY <= 1'h1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_ARREADY <= 1'h1;
      O_RVALID <= 1'h0;
      O_RDATA <= 32'h0;
      O_RRESP <= RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_ARREADY <= 1'h0;
      O_RVALID <= 1'h1;
      O_RDATA <= rd_mux;
      O_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'h0;
      O_ARREADY <= 1'h1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_r <= S_IDLE;
      op_r <= OP_NONE;
      go_r <= 1'h0;
      rd_r <= 1'h0;
      wd_r <= 16'h0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      go_r <= go_nxt;
      rd_r <= st_nxt == S_POLL || st_nxt == S_RDA;
      wd_r <= cmd_word(st_nxt, op_nxt, data_r[7:0]);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      addr_r <= '0;
      data_r <= 16'h0;
      O_FL_WP_N <= WP_RST;
      O_FL_RP_N <= RP_RST;
    end else begin
      if (wr_fire && awaddr_r == REG_ADDR) addr_r <= AW'(merge(32'(addr_r), wdata_r, wstrb_r));
      if (wr_fire && awaddr_r == REG_DATA) data_r <= 16'(merge({16'h0, data_r}, wdata_r, wstrb_r));
      if (wr_ctrl) O_FL_RP_N <= rp_new;
      // A changing protect level during suspend gives spurious results
      if (wr_ctrl && !susp_r) O_FL_WP_N <= wdata_r[CTRL_WP_BIT];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      susp_r <= 1'h0;
      unknown_r <= 1'h0;
      mode_r <= STS_LEVEL;
      stat_r <= 8'h0;
      array_r <= 16'h0;
    end else begin
      if (poll_end) stat_r <= eng_rdata[7:0];
      if (st_r == S_RDA && eng_done) array_r <= eng_rdata;
      if (poll_end && op_r == OP_SUSPEND) susp_r <= eng_rdata[SB_SUSP];
      if (st_r == S_CMD1 && eng_done && op_r == OP_RESUME) susp_r <= 1'h0;
      if (poll_end && op_r == OP_CLRLOCK && !fail) unknown_r <= 1'h0;
      if (cfg_end && data_r[7:2] == 6'h0) mode_r <= data_r[1:0];
      if (abort) begin
        susp_r <= 1'h0;
        mode_r <= STS_LEVEL;
        if (st_r != S_IDLE && op_r == OP_CLRLOCK) unknown_r <= 1'h1;
      end
    end
  end

  // Sticky flags: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      refused_r <= 1'h0;
      pulse_r <= 1'h0;
      sts_r <= 1'h1;
    end else begin
      sts_r <= I_FL_STS;
      refused_r <= refuse || (refused_r && !(wr_stat && wdata_r[STAT_REFUSED_BIT]));
      pulse_r <= pulse_evt || (pulse_r && !(wr_stat && wdata_r[STAT_PULSE_BIT]));
    end
  end

  fsps_bus_cycle #(.AW(AW)) u_bus (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_go(go_r),
    .i_rd(rd_r),
    .i_addr(addr_r),
    .i_wdata(wd_r),
    .i_dq(I_FL_DQ),
    .o_done(eng_done),
    .o_rdata(eng_rdata),
    .o_addr(O_FL_ADDR),
    .o_dq(O_FL_DQ),
    .o_dq_oe_n(O_FL_DQ_OE_N),
    .o_ce_n(O_FL_CE_N),
    .o_we_n(O_FL_WE_N),
    .o_oe_n(O_FL_OE_N)
  );

  a_wp_frozen: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(susp_r) |-> $stable(O_FL_WP_N)) else $error("WP moved while suspended");
  a_lock_two_writes: assert property (@(posedge I_CLK) disable iff (I_RST)
    st_r == S_CMD1 && eng_done && lock_op && !abort |=> st_r == S_CMD2 ##[1:12] eng_done)
    else $error("Lock setup not followed by confirm");
  a_cfg_rp_high: assert property (@(posedge I_CLK) disable iff (I_RST)
    st_r == S_CMD2 && op_r == OP_STSCFG |-> O_FL_RP_N) else $error("Config with RP low");
  a_mode_default: assert property (@(posedge I_CLK) disable iff (I_RST)
    $fell(O_FL_RP_N) |-> mode_r == STS_LEVEL) else $error("Pin mode kept over reset");
  a_clear_on_err: assert property (@(posedge I_CLK) disable iff (I_RST)
    poll_end && fail && ready && !abort |=> st_r == S_CLRS) else $error("Error left uncleared");
  a_reclear_go: assert property (@(posedge I_CLK) disable iff (I_RST)
    auto_go |=> st_r == S_CMD1 && op_r == OP_CLRLOCK) else $error("No repeat of clear");
  a_resume_clr: assert property (@(posedge I_CLK) disable iff (I_RST)
    st_r == S_CMD1 && op_r == OP_RESUME && eng_done && !abort |=> !susp_r && st_r == S_POLL)
    else $error("Resume did not clear suspend");
  a_refuse_flag: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_ctrl && susp_r && st_r == S_IDLE &&
    req_op inside {OP_SUSPEND, OP_SETLOCK, OP_CLRLOCK, OP_STSCFG}
    |=> refused_r && st_r == S_IDLE) else $error("Illegal command while suspended");
endmodule

// file: sim/fsps_flash_model.sv
// Behavioural flash device seen from the host: commands, status byte, status pin
`timescale 1ns/100ps
module fsps_flash_model import fsps_pkg::*; #(
  parameter int BUSY_CYC = 60,
  parameter int PROG_CYC = 200,
  parameter int PULSE_CYC = 2
) (
  input wire logic i_clk,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [20:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_wp_n,
  input wire logic i_rp_n,
  input wire logic i_vpp_low,
  input wire logic i_prog_req,
  output logic [15:0] o_dq,
  output logic o_sts_oe_n,
  output logic o_locked
);
  logic we_r, rd_stat_r, susp_r, sreq_r;
  logic [1:0] pend_r, kind_r, mode_r;
  logic [7:0] sr_r, c;
  logic [15:0] last_r;
  int cnt_r, pcnt_r;
  wire rdy = (cnt_r == 0) || susp_r;
  wire [7:0] stat = {rdy, sr_r[6:3], susp_r, sr_r[1:0]};
  wire drive = !i_ce_n && !i_oe_n;
  wire [15:0] val = rd_stat_r ? {8'h00, stat} : ~i_addr[15:0];
  // Released bus shows the inverse of the last value so a late sample cannot pass by luck
  assign o_dq = drive ? val : ~last_r;
  assign o_sts_oe_n = !((mode_r == 2'h0 && !rdy) || pcnt_r != 0);
  initial o_locked = 1'b0;
  always @(posedge i_clk) begin
    c = i_dq[7:0];
    we_r <= i_we_n;
    if (drive) last_r <= val;
    if (pcnt_r != 0) pcnt_r <= pcnt_r - 1;
    if (i_rp_n !== 1'b1) begin
      {rd_stat_r, susp_r, sreq_r, pend_r, kind_r, mode_r, sr_r, cnt_r, pcnt_r} <= '0;
    end else begin
      if (i_prog_req && cnt_r == 0) begin
        cnt_r <= PROG_CYC;
        kind_r <= 2'h1;
      end
      if (cnt_r != 0 && !susp_r) begin
        // Suspend only lands on an 8-cycle boundary of the algorithm
        if (sreq_r && cnt_r[2:0] == 3'h0) begin
          susp_r <= 1'b1;
          sreq_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r - 1;
          if (cnt_r == 1) begin
            if (kind_r == 2'h2) o_locked <= 1'b1;
            if (kind_r == 2'h3) o_locked <= 1'b0;
            if (kind_r == 2'h3 ? mode_r[0] : mode_r[1]) pcnt_r <= PULSE_CYC;
          end
        end
      end
      if (!i_ce_n && i_we_n && !we_r) begin
        if (pend_r == 2'h1) begin
          pend_r <= 2'h0;
          if (c == CMD_SETCONF && !i_wp_n) sr_r <= sr_r | 8'h12;
          else if (c == CMD_SETCONF) {cnt_r, kind_r} <= {BUSY_CYC, 2'h2};
          else if (c == CMD_CONFIRM && i_vpp_low) sr_r <= sr_r | 8'h28;
          else if (c == CMD_CONFIRM && !i_wp_n) sr_r <= sr_r | 8'h22;
          else if (c == CMD_CONFIRM) {cnt_r, kind_r} <= {BUSY_CYC, 2'h3};
          else sr_r <= sr_r | 8'h30;
        end else if (pend_r == 2'h2) begin
          pend_r <= 2'h0;
          if (c < 8'h04) mode_r <= c[1:0];
        end else if (susp_r && !(c inside {CMD_RDARRAY, CMD_RDSTAT, CMD_CONFIRM})) begin
          // Anything else while suspended is flagged so a leaked command shows up
          sr_r <= sr_r | 8'h30;
        end else begin
          case (c)
            CMD_LOCKSET: {pend_r, rd_stat_r} <= {2'h1, 1'b1};
            CMD_STSCFG: pend_r <= 2'h2;
            CMD_RDSTAT: rd_stat_r <= 1'b1;
            CMD_CLRSTAT: sr_r <= 8'h00;
            CMD_RDARRAY: rd_stat_r <= 1'b0;
            CMD_SUSPEND: {sreq_r, rd_stat_r} <= {kind_r == 2'h1 && cnt_r != 0, 1'b1};
            CMD_CONFIRM: if (susp_r) {susp_r, rd_stat_r} <= 2'h1;
            default: sr_r <= sr_r | 8'h30;
          endcase
        end
      end
    end
  end
endmodule

// file: sim/fsps_host_test.sv
// Self-checking bench for the flash command host over AXI4-Lite
`timescale 1ns/100ps
module fsps_host_test import fsps_pkg::*;;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, vpp_low, prog_req;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, st;
  logic [1:0] resp;
  wire awready, wready, bvalid, arready, rvalid, ce_n, we_n, oe_n, dq_oe_n, wp_n, rp_n;
  wire sts_oe_n, locked;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [20:0] fl_addr;
  wire [15:0] fl_dq, fl_din;
  wire [15:0] dq_bus = dq_oe_n ? fl_din : fl_dq;
  // Status pin is open drain with a pull-up
  wire sts = sts_oe_n ? 1'b1 : 1'b0;
  int err_count, checks, cyc;

  fsps_host #(.AW(21)) i_dut (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_FL_ADDR(fl_addr), .O_FL_DQ(fl_dq), .O_FL_DQ_OE_N(dq_oe_n), .I_FL_DQ(dq_bus),
    .O_FL_CE_N(ce_n), .O_FL_WE_N(we_n), .O_FL_OE_N(oe_n), .O_FL_WP_N(wp_n),
    .O_FL_RP_N(rp_n), .I_FL_STS(sts));
  fsps_flash_model i_flash (.i_clk(clk), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_addr(fl_addr), .i_dq(dq_bus), .i_wp_n(wp_n), .i_rp_n(rp_n), .i_vpp_low(vpp_low),
    .i_prog_req(prog_req), .o_dq(fl_din), .o_sts_oe_n(sts_oe_n), .o_locked(locked));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task end_sim;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    {st, resp} = {rdata, rresp};
    rready <= 1'b0;
  endtask

  // Flash op with RP high; returns once the host reports idle, last STAT in st
  task automatic op(input logic [2:0] o, input logic wp);
    wr(REG_CTRL, {22'h0, 1'b1, wp, 5'h00, o});
    do rd(REG_STAT); while (st[0] !== 1'b0);
  endtask

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, vpp_low, prog_req} = 8'h80;
    {awaddr, araddr, wdata} = '0;
    {err_count, checks, cyc} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CTRL); chk(st, 32'h0);
    rd(REG_STAT); chk(st & 32'h3FFFF, 32'h20);
    wr(8'h40, 32'h3); chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(8'h44); chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(REG_CTRL, 32'h300); rd(REG_CTRL); chk(st, 32'h300);
    wr(REG_ADDR, 32'h1234);
    op(3'h3, 1'b1); chk(st & 32'hFF00, 32'h8000);
    chk({31'h0, locked}, 32'h1);
    op(3'h3, 1'b0); chk(st & 32'hFF00, 32'h9200);
    vpp_low <= 1'b1;
    op(3'h4, 1'b1); chk(st & 32'hFF00, 32'hA800);
    vpp_low <= 1'b0;
    op(3'h4, 1'b0); chk(st & 32'hFF00, 32'hA200);
    op(3'h4, 1'b1); chk(st & 32'hFF08, 32'h8000);
    chk({31'h0, locked}, 32'h0);
    op(3'h6, 1'b1); chk(st & 32'hFF00, 32'h8000);
    for (int m = 0; m < 4; m++) begin
      wr(REG_DATA, m); op(3'h5, 1'b1); chk(st & 32'h30000, m << 16);
      wr(REG_STAT, 32'h10); op(3'h3, 1'b1); chk(st & 32'h10, m[1] << 4);
      wr(REG_STAT, 32'h10); op(3'h4, 1'b1); chk(st & 32'h10, m[0] << 4);
    end
    wr(REG_DATA, 32'h4); op(3'h5, 1'b1); chk(st & 32'h30000, 32'h30000);
    // Level mode, so the released pin during suspend means something
    wr(REG_DATA, 32'h0); op(3'h5, 1'b1); chk(st & 32'h30000, 32'h0);
    prog_req <= 1'b1;
    @(posedge clk);
    prog_req <= 1'b0;
    op(3'h1, 1'b1); chk(st & 32'hFF02, 32'h8402);
    chk({31'h0, sts}, 32'h1);
    op(3'h3, 1'b1); chk(st & 32'h6, 32'h6);
    chk({31'h0, locked}, 32'h0);
    op(3'h6, 1'b0); rd(REG_CTRL); chk(st & 32'h300, 32'h300);
    wr(REG_STAT, 32'h4);
    wr(REG_ADDR, 32'h55); op(3'h7, 1'b1); rd(REG_ARRAY); chk(st & 32'hFFFF, 32'hFFAA);
    op(3'h2, 1'b1); chk(st & 32'hFF02, 32'h8000);
    op(3'h3, 1'b1);
    wr(REG_DATA, 32'h3); op(3'h5, 1'b1);
    wr(REG_CTRL, 32'h304); wr(REG_CTRL, 32'h100);
    rd(REG_STAT); chk(st & 32'h30008, 32'h8);
    wr(REG_CTRL, 32'h300);
    do rd(REG_STAT); while (st[3] !== 1'b0 || st[0] !== 1'b0);
    chk({31'h0, locked}, 32'h0);
    end_sim;
  end
endmodule
